// [hdl/osc_pkg.sv]
// oscillator select control: shared offsets, field layout, reset values
// assumes one system clock and an AHB-Lite slave port for software access
package osc_pkg;

	// ********************************
	// register map (word aligned)
	// ********************************
	localparam logic [31:0] OSC_CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] OSC_KEY_OFS  = 32'h0000_0004;

	// ********************************
	// field positions
	// ********************************
	localparam int OSC_DIV_LSB   = 24;
	localparam int OSC_MULT_LSB  = 16;
	localparam int OSC_CUR_LSB   = 12;
	localparam int OSC_REQ_LSB   = 8;
	localparam int OSC_LOCK_BIT  = 7;
	localparam int OSC_USB_LOOP_LOCKED_BIT = 6;
	localparam int OSC_SYS_LOOP_LOCKED_BIT = 5;
	localparam int OSC_SLEEP_BIT = 4;
	localparam int OSC_SYNC_W    = 3;

	// ********************************
	// reset values and constants
	// ********************************
	localparam logic [2:0]  OSC_MULT_RST   = 3'h0;
	localparam logic [2:0]  OSC_DIV_RST    = 3'h0;
	localparam logic        OSC_SLEEP_RST  = 1'h0;
	localparam logic        OSC_LOCK_RST   = 1'h0;
	localparam logic [2:0]  OSC_MULT_TOP   = 3'h7;
	localparam logic [4:0]  OSC_FACT_BASE  = 5'h0F;
	localparam logic [4:0]  OSC_FACT_TOP   = 5'h18;
	localparam logic [31:0] OSC_KEY_FIRST  = 32'hAA99_6655;
	localparam logic [31:0] OSC_KEY_SECOND = 32'h5566_99AA;

	// ********************************
	// state machines
	// ********************************
	typedef enum logic [2:0] {
		SW_IDLE = 3'b001,
		SW_REQ  = 3'b010,
		SW_DONE = 3'b100
	} osc_sw_t;

	typedef enum logic [2:0] {
		UL_SHUT = 3'b001,
		UL_HALF = 3'b010,
		UL_OPEN = 3'b100
	} osc_ul_t;

endpackage : osc_pkg

// [hdl/osc_sync_if.sv]
// carrier between the control block and its pin synchroniser
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface osc_sync_if;
	import osc_pkg::*;
	logic [OSC_SYNC_W-1:0] raw;
	logic [OSC_SYNC_W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface : osc_sync_if

// [hdl/osc_pin_sync.sv]
// three-stage input synchroniser with agreement filter per bit
// assumes inputs are asynchronous levels, slow against the clock
`timescale 1ns/1ns
module osc_pin_sync
	import osc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	osc_sync_if.sync bus
);

	// ********************************
	// per-bit synchroniser
	// ********************************
	genvar gi;
	generate
		for (gi = 0; gi < OSC_SYNC_W; gi++) begin : gBit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic out_r;
			// first stage feeds only the second
			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					s1_r  <= 1'h0;
					s2_r  <= 1'h0;
					s3_r  <= 1'h0;
					out_r <= 1'h0;
				end else begin
					s1_r <= bus.raw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
					// a change counts once stages two and three agree
					if (s2_r == s3_r) begin
						out_r <= s3_r;
					end
				end
			end
			assign bus.clean[gi] = out_r;
		end
	endgenerate

endmodule : osc_pin_sync

// [hdl/osc_select_ctrl.sv]
// oscillator select control: control register, unlock gate, switch handshake
// assumes AHB-Lite single word transfers, config word stable on clk_sys,
// lock and switch-done levels arriving asynchronously from the clock tree
//
// Behaviour
// - multiplier code 0-6 selects factor 15-21, code 7 selects 24
// - current-source field reports the active source with the eight-code set
// - requested-source field is the target of a clock switch
// - reset loads requested source from the start-up config, not a constant
// - with monitor config 1x, a set lock bit freezes clock and loop selections
// - with monitor config 0x, the lock bit is ignored
// - usb loop lock flag follows the usb loop lock status
// - system loop lock flag follows the system loop lock status
// - wait gives sleep when sleep enable is 1, idle when 0
// - control writes are ignored unless an unlock sequence preceded them
// - unimplemented bits, including 15 and 11, read as zero
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module osc_select_ctrl
	import osc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic [2:0]  startupSourceCfg,
	input  wire logic [1:0]  switchMonitorCfg,
	input  wire logic        sysLoopLockIn,
	input  wire logic        usbLoopLockIn,
	input  wire logic        switchDoneIn,
	input  wire logic        waitExec,
	output logic             switchReq,
	output logic      [2:0]  switchTarget,
	output logic      [4:0]  loopMultFactor,
	output logic      [2:0]  fastRcDivider,
	output logic             sleepEnter,
	output logic             idleEnter
);

	// ********************************
	// declarations
	// ********************************
	logic [2:0]  multSel_r;
	logic [2:0]  divSel_r;
	logic [2:0]  reqSrc_r;
	logic [2:0]  curSrc_r;
	logic        lockBit_r;
	logic        sleepBit_r;
	logic        wrPend_r;
	logic [31:0] wrAddr_r;
	logic        hreadyout_r;
	logic [31:0] hrdata_r;
	logic        hresp_r;
	logic        switchReq_r;
	logic [2:0]  switchTarget_r;
	logic [4:0]  loopMultFactor_r;
	logic        sleepEnter_r;
	logic        idleEnter_r;
	osc_sw_t     swState_r;
	osc_ul_t     ulState_r;
	logic        addrPhase;
	logic        selLocked;
	logic        ctrlWrite;
	logic        ctrlAccept;
	logic        keyWrite;
	logic        usbLocked;
	logic        sysLocked;
	logic        switchDone;
	logic [31:0] ctrlView;
	logic [31:0] keyView;
	logic [2:0]  wrMult;
	logic [2:0]  wrReq;
	logic [2:0]  wrDiv;

	// ********************************
	// pin synchroniser
	// ********************************
	osc_sync_if syncBus ();

	assign syncBus.raw = {switchDoneIn, usbLoopLockIn, sysLoopLockIn};
	assign sysLocked   = syncBus.clean[0];
	assign usbLocked   = syncBus.clean[1];
	assign switchDone  = syncBus.clean[2];

	osc_pin_sync uSync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.bus     (syncBus)
	);

	// ********************************
	// bus decode
	// ********************************
	// zero wait state slave, so hsel, hready and htrans[1] together mark a taken address phase
	assign addrPhase = hsel & hready & htrans[1];
	// selections frozen only when monitoring config is 1x
	assign selLocked = switchMonitorCfg[1] & lockBit_r;
	assign ctrlWrite = wrPend_r & (wrAddr_r == OSC_CTRL_OFS);
	assign keyWrite  = wrPend_r & (wrAddr_r == OSC_KEY_OFS);
	assign ctrlAccept = ctrlWrite & (ulState_r == UL_OPEN);
	assign wrMult = hwdata[OSC_MULT_LSB +: 3];
	assign wrReq  = hwdata[OSC_REQ_LSB +: 3];
	assign wrDiv  = hwdata[OSC_DIV_LSB +: 3];

	// read views; every unlisted bit stays zero
	always_comb begin
		ctrlView = 32'h0000_0000;
		ctrlView[OSC_DIV_LSB +: 3]  = divSel_r;
		ctrlView[OSC_MULT_LSB +: 3] = multSel_r;
		ctrlView[OSC_CUR_LSB +: 3]  = curSrc_r;
		ctrlView[OSC_REQ_LSB +: 3]  = reqSrc_r;
		ctrlView[OSC_LOCK_BIT]      = lockBit_r;
		ctrlView[OSC_USB_LOOP_LOCKED_BIT]     = usbLocked;
		ctrlView[OSC_SYS_LOOP_LOCKED_BIT]     = sysLocked;
		ctrlView[OSC_SLEEP_BIT]     = sleepBit_r;
		keyView = 32'h0000_0000;
		keyView[0] = (ulState_r == UL_OPEN);
	end

	// address phase capture; data applied in the following data phase
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wrPend_r <= 1'h0;
			wrAddr_r <= 32'h0000_0000;
		end else begin
			wrPend_r <= addrPhase & hwrite;
			if (addrPhase) begin
				wrAddr_r <= haddr;
			end
		end
	end

	// read data registered at the address phase edge;
	// a read right behind a write would see the old value, the master idles between
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			if (haddr == OSC_CTRL_OFS) begin
				hrdata_r <= ctrlView;
			end else if (haddr == OSC_KEY_OFS) begin
				hrdata_r <= keyView;
			end else begin
				hrdata_r <= 32'h0000_0000;
			end
		end
	end

	// always ready, always okay; kept as flops so every output is registered
	always_ff @(posedge clk_sys) begin
		hreadyout_r <= 1'h1;
		hresp_r     <= 1'h0;
	end

	assign hreadyout = hreadyout_r;
	assign hrdata    = hrdata_r;
	assign hresp     = hresp_r;

	// ********************************
	// unlock sequence
	// ********************************
	// two keys in order open a single control write; any other key or control write shuts it
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ulState_r <= UL_SHUT;
		end else if (keyWrite) begin
			case (ulState_r)
				UL_SHUT: begin
					ulState_r <= (hwdata == OSC_KEY_FIRST) ? UL_HALF : UL_SHUT;
				end
				UL_HALF: begin
					ulState_r <= (hwdata == OSC_KEY_SECOND) ? UL_OPEN : UL_SHUT;
				end
				default: begin
					ulState_r <= UL_SHUT;
				end
			endcase
		end else if (ctrlWrite) begin
			ulState_r <= UL_SHUT;
		end
	end

	// ********************************
	// control fields
	// ********************************
	// selections obey the lock; lock and sleep bits take any unlocked write, lock or not
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			multSel_r  <= OSC_MULT_RST;
			divSel_r   <= OSC_DIV_RST;
			lockBit_r  <= OSC_LOCK_RST;
			sleepBit_r <= OSC_SLEEP_RST;
		end else if (ctrlAccept) begin
			lockBit_r  <= hwdata[OSC_LOCK_BIT];
			sleepBit_r <= hwdata[OSC_SLEEP_BIT];
			if (!selLocked) begin
				multSel_r <= wrMult;
				divSel_r  <= wrDiv;
			end
		end
	end

	// requested source: strap at reset, held while a switch is running
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reqSrc_r <= startupSourceCfg;
		end else if (ctrlAccept && !selLocked && swState_r == SW_IDLE) begin
			reqSrc_r <= wrReq;
		end
	end

	// ********************************
	// multiplier factor
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			loopMultFactor_r <= OSC_FACT_BASE;
		end else if (multSel_r == OSC_MULT_TOP) begin
			loopMultFactor_r <= OSC_FACT_TOP;
		end else begin
			loopMultFactor_r <= OSC_FACT_BASE + {2'h0, multSel_r};
		end
	end

	assign loopMultFactor = loopMultFactor_r;
	assign fastRcDivider  = divSel_r;

	// ********************************
	// clock switch handshake
	// ********************************
	// request held until the clock tree reports done, then wait for done to drop
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			swState_r      <= SW_IDLE;
			switchReq_r    <= 1'h0;
			switchTarget_r <= startupSourceCfg;
			curSrc_r       <= startupSourceCfg;
		end else begin
			case (swState_r)
				SW_IDLE: begin
					if (reqSrc_r != curSrc_r && !switchDone) begin
						swState_r      <= SW_REQ;
						switchReq_r    <= 1'h1;
						switchTarget_r <= reqSrc_r;
					end
				end
				SW_REQ: begin
					if (switchDone) begin
						swState_r   <= SW_DONE;
						switchReq_r <= 1'h0;
						curSrc_r    <= switchTarget_r;
					end
				end
				SW_DONE: begin
					if (!switchDone) begin
						swState_r <= SW_IDLE;
					end
				end
				default: begin
					swState_r   <= SW_IDLE;
					switchReq_r <= 1'h0;
				end
			endcase
		end
	end

	assign switchReq    = switchReq_r;
	assign switchTarget = switchTarget_r;

	// ********************************
	// wait instruction response
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sleepEnter_r <= 1'h0;
			idleEnter_r  <= 1'h0;
		end else begin
			sleepEnter_r <= waitExec & sleepBit_r;
			idleEnter_r  <= waitExec & ~sleepBit_r;
		end
	end

	assign sleepEnter = sleepEnter_r;
	assign idleEnter  = idleEnter_r;

	// ********************************
	// assertions
	// ********************************
	chk_mult_top: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(multSel_r == OSC_MULT_TOP) |=> (loopMultFactor == 5'h18))
		else $error("factor for top code is not 24");

	chk_mult_low: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(multSel_r == 3'h6) |=> (loopMultFactor == 5'h15))
		else $error("factor for code six is not 21");

	chk_cur_read: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(addrPhase && !hwrite && haddr == OSC_CTRL_OFS)
		|=> (hrdata[14:12] == $past(curSrc_r)))
		else $error("current source read back wrong");

	chk_switch_target: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		$rose(switchReq) |-> (switchTarget == $past(reqSrc_r)))
		else $error("switch target differs from request");

	chk_reset_strap: assert property (
		@(posedge clk_sys)
		!nrst |=> (reqSrc_r == $past(startupSourceCfg)))
		else $error("requested source not loaded from config");

	chk_lock_hold: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(ctrlAccept && switchMonitorCfg[1] && lockBit_r)
		|=> $stable(multSel_r) && $stable(reqSrc_r))
		else $error("locked selection changed");

	chk_lock_ignored: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(ctrlAccept && !switchMonitorCfg[1])
		|=> (multSel_r == $past(wrMult)))
		else $error("selection blocked with monitor config 0x");

	chk_usb_flag: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(addrPhase && !hwrite && haddr == OSC_CTRL_OFS)
		|=> (hrdata[6] == $past(usbLocked)))
		else $error("usb lock flag wrong");

	chk_sys_flag: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(addrPhase && !hwrite && haddr == OSC_CTRL_OFS)
		|=> (hrdata[5] == $past(sysLocked)))
		else $error("system lock flag wrong");

	chk_wait_mode: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		waitExec |=> (sleepEnter == $past(sleepBit_r)) && (idleEnter != sleepEnter))
		else $error("wait gave the wrong power mode");

	chk_write_gate: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(ctrlWrite && ulState_r != UL_OPEN)
		|=> $stable(multSel_r) && $stable(sleepBit_r) && $stable(lockBit_r))
		else $error("write took effect without unlock");

	chk_zero_bits: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		(addrPhase && !hwrite && haddr == OSC_CTRL_OFS)
		|=> (hrdata[15] == 1'h0) && (hrdata[11] == 1'h0) && (hrdata[3:0] == 4'h0))
		else $error("unimplemented bit reads as one");

	chk_cur_on_done: assert property (
		@(posedge clk_sys) disable iff (!nrst)
		($past(nrst) && $changed(curSrc_r))
		|-> ($past(swState_r) == SW_REQ) && $past(switchDone))
		else $error("current source moved without a completed switch");

endmodule : osc_select_ctrl

// [dv/osc_select_ctrl_tb.sv]
// self-checking bench for the oscillator select control block
// assumes zero-wait AHB-Lite slave, hready looped back from hreadyout
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD %0t got %h expected %h", $time, got, exp); end end

module osc_select_ctrl_tb;
	import osc_pkg::*;

	// ********************************
	// stimulus and observation signals
	// ********************************
	localparam logic [2:0] BOOT_SRC = 3'h2;
	localparam logic [2:0] NEW_SRC  = 3'h5;
	logic        clk_sys = 1'b0;
	logic        nrst, hsel, hwrite, hreadyout, hresp, waitExec;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, switchMonitorCfg;
	logic        sysLoopLockIn, usbLoopLockIn, switchDoneIn;
	logic        switchReq, sleepEnter, idleEnter;
	logic [2:0]  switchTarget, fastRcDivider, curSrc, bootSrc;
	logic [4:0]  loopMultFactor;
	int          n_errors = 0;
	int          tests_run = 0;

	always #25 clk_sys = ~clk_sys;

	osc_select_ctrl dut_u (
		.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.startupSourceCfg(bootSrc), .switchMonitorCfg(switchMonitorCfg),
		.sysLoopLockIn(sysLoopLockIn), .usbLoopLockIn(usbLoopLockIn),
		.switchDoneIn(switchDoneIn), .waitExec(waitExec), .switchReq(switchReq),
		.switchTarget(switchTarget), .loopMultFactor(loopMultFactor),
		.fastRcDivider(fastRcDivider), .sleepEnter(sleepEnter), .idleEnter(idleEnter)
	);

	// ********************************
	// bus helpers
	// ********************************
	// one single transfer; address held until taken, data until answered
	task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
			output logic [31:0] rdat);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= addr;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask : ahb

	// key pair then the control write; the factor register lags the field
	// by one edge, so two extra edges before anyone looks at outputs
	task automatic wr_ctrl(input logic [31:0] v);
		logic [31:0] d;
		ahb(1'b1, OSC_KEY_OFS, OSC_KEY_FIRST, d);
		ahb(1'b1, OSC_KEY_OFS, OSC_KEY_SECOND, d);
		ahb(1'b1, OSC_CTRL_OFS, v, d);
		repeat (2) @(posedge clk_sys);
	endtask : wr_ctrl

	task automatic rd_ctrl(output logic [31:0] v);
		ahb(1'b0, OSC_CTRL_OFS, 32'h0000_0000, v);
	endtask : rd_ctrl

	function automatic logic [31:0] cw(input logic [2:0] div, input logic [2:0] mult,
			input logic [2:0] req, input logic lock, input logic slp);
		return {5'h00, div, 5'h00, mult, 5'h00, req, lock, 2'b00, slp, 4'h0};
	endfunction : cw

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		rd_ctrl(rd);
		`CHK(rd, cw(3'h0, 3'h0, BOOT_SRC, 1'b0, 1'b0) | {17'h0, BOOT_SRC, 12'h0})
		`CHK(switchTarget, BOOT_SRC)
		`CHK(loopMultFactor, 5'h0F)
		`CHK(hresp, 1'b0)
		$display("test reset done");
	endtask : t_reset

	task automatic t_nounlock();
		ahb(1'b1, OSC_CTRL_OFS, cw(3'h4, 3'h3, BOOT_SRC, 1'b0, 1'b1), rd);
		// a wrong second key must shut the gate again
		ahb(1'b1, OSC_KEY_OFS, OSC_KEY_FIRST, rd);
		ahb(1'b1, OSC_KEY_OFS, 32'h0000_0000, rd);
		ahb(1'b1, OSC_CTRL_OFS, cw(3'h4, 3'h3, BOOT_SRC, 1'b0, 1'b1), rd);
		rd_ctrl(rd);
		`CHK(rd, cw(3'h0, 3'h0, BOOT_SRC, 1'b0, 1'b0) | {17'h0, BOOT_SRC, 12'h0})
		`CHK(loopMultFactor, 5'h0F)
		ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
		ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		$display("test unlock gate done");
	endtask : t_nounlock

	// every multiplier code, junk in unimplemented bits 31:27, 15 and 11
	task automatic t_mult();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr_ctrl(cw(c, c, curSrc, 1'b0, 1'b0) | 32'hF800_8800);
			rd_ctrl(rd);
			`CHK(rd, cw(c, c, curSrc, 1'b0, 1'b0) | {17'h0, curSrc, 12'h0})
			`CHK(loopMultFactor, (c == 3'h7) ? 5'h18 : 5'h0F + 5'(c))
			`CHK(fastRcDivider, c)
		end
		$display("test multiplier done");
	endtask : t_mult

	// synchronisers need a few cycles before the flags show
	task automatic t_status();
		sysLoopLockIn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_ctrl(rd);
		`CHK(rd[5], 1'b1)
		`CHK(rd[6], 1'b0)
		sysLoopLockIn <= 1'b0;
		usbLoopLockIn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_ctrl(rd);
		`CHK(rd[6], 1'b1)
		`CHK(rd[5], 1'b0)
		usbLoopLockIn <= 1'b0;
		$display("test lock flags done");
	endtask : t_status

	task automatic t_wait();
		logic seenS, seenI;
		for (int s = 0; s < 2; s++) begin
			wr_ctrl(cw(3'h0, 3'h0, curSrc, 1'b0, 1'(s)));
			waitExec <= 1'b1;
			@(posedge clk_sys);
			waitExec <= 1'b0;
			seenS = 1'b0;
			seenI = 1'b0;
			repeat (3) begin
				@(posedge clk_sys);
				seenS = seenS | sleepEnter;
				seenI = seenI | idleEnter;
			end
			`CHK(seenS, 1'(s))
			`CHK(seenI, 1'(1 - s))
		end
		$display("test wait mode done");
	endtask : t_wait

	// current source must hold the old value until done is reported
	task automatic t_switch();
		int n;
		wr_ctrl(cw(3'h0, 3'h0, NEW_SRC, 1'b0, 1'b0));
		for (n = 0; n < 10 && switchReq !== 1'b1; n++) @(posedge clk_sys);
		`CHK(switchReq, 1'b1)
		`CHK(switchTarget, NEW_SRC)
		rd_ctrl(rd);
		`CHK(rd[14:12], BOOT_SRC)
		switchDoneIn <= 1'b1;
		for (n = 0; n < 20 && switchReq !== 1'b0; n++) @(posedge clk_sys);
		`CHK(switchReq, 1'b0)
		rd_ctrl(rd);
		`CHK(rd[14:12], NEW_SRC)
		`CHK(rd[10:8], NEW_SRC)
		switchDoneIn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		curSrc = NEW_SRC;
		$display("test clock switch done");
	endtask : t_switch

	task automatic t_lock();
		switchMonitorCfg <= 2'b10;
		wr_ctrl(cw(3'h0, 3'h3, curSrc, 1'b1, 1'b0));
		`CHK(loopMultFactor, 5'h12)
		wr_ctrl(cw(3'h0, 3'h5, 3'h1, 1'b1, 1'b0));
		`CHK(loopMultFactor, 5'h12)
		rd_ctrl(rd);
		`CHK(rd[10:8], curSrc)
		wr_ctrl(cw(3'h0, 3'h3, curSrc, 1'b0, 1'b0));
		wr_ctrl(cw(3'h0, 3'h5, curSrc, 1'b0, 1'b0));
		`CHK(loopMultFactor, 5'h14)
		switchMonitorCfg <= 2'b01;
		wr_ctrl(cw(3'h0, 3'h6, curSrc, 1'b1, 1'b0));
		wr_ctrl(cw(3'h0, 3'h2, curSrc, 1'b1, 1'b0));
		`CHK(loopMultFactor, 5'h11)
		// the unlock opened one write only; a bare second write is dropped
		ahb(1'b1, OSC_CTRL_OFS, cw(3'h0, 3'h7, curSrc, 1'b0, 1'b0), rd);
		repeat (2) @(posedge clk_sys);
		`CHK(loopMultFactor, 5'h11)
		$display("test selection lock done");
	endtask : t_lock

	// second reset with another start-up code; both source fields follow it
	task automatic t_rereset();
		bootSrc <= 3'h6;
		nrst    <= 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		curSrc = 3'h6;
		rd_ctrl(rd);
		`CHK(rd, cw(3'h0, 3'h0, 3'h6, 1'b0, 1'b0) | {17'h0, 3'h6, 12'h0})
		`CHK(switchTarget, 3'h6)
		`CHK(switchReq, 1'b0)
		$display("test second reset done");
	endtask : t_rereset

	// ********************************
	// verdict, watchdog, main sequence
	// ********************************
	task automatic close_out();
		$display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// whole run needs well under 2000 cycles; ten times that is a hang
	initial begin
		#(50 * 20000);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		switchMonitorCfg = 2'b00;
		sysLoopLockIn = 1'b0;
		usbLoopLockIn = 1'b0;
		switchDoneIn = 1'b0;
		waitExec = 1'b0;
		curSrc = BOOT_SRC;
		bootSrc = BOOT_SRC;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		t_reset();
		t_nounlock();
		t_mult();
		t_status();
		t_wait();
		t_switch();
		t_lock();
		t_rereset();
		close_out();
	end

endmodule : osc_select_ctrl_tb
